// file: logic/cptc_defs.vh
// constants for the continuous period timestamp capture block
// How it works
// - start only runs the counter; capture waits for a collection request.
// - a collection request also starts a stopped counter.
// - stop halts the counter and flushes every pending sample.
// - stop ends any interrupt or transfer-driven collection in progress.
// - an overrun still latched at stop is reported to the host.
// - gate enable chooses ungated (0) or gate-qualified (1) capture.
// - gate polarity chooses active high (1) or active low (0).
// - edge count chooses single edge (0) or both edges (1).
// - single edge select picks rising (0) or falling (1).
// - gate usage picks one-time trigger (0) or level gate (1).
// - counter advances every 0.1 us; unscaled delta spans 65535 counts.
// - delta is current minus previous, shifted right by scale 0..28, 16 bits.
// - scaled delta above 65535 reads zero with overflow flagged.
// - sample leaves as four bytes, least significant first, bits 11:4, 19:12, 27:20.
// - first byte holds count bits 3:0, inverted gate, inverted signal, two zeros.
// - counted collection stops and flushes on count done or overrun.
`ifndef CPTC_DEFS_VH
`define CPTC_DEFS_VH
`define CPTC_CNT_W        28
`define CPTC_CLK_PERIOD_PS 4000
`define CPTC_TICK_PS      100000
// one count is 0.1 us, which is 25 clocks of 4 ns; keep it in step with the clock
`define CPTC_TICK_CYC     5'h19
`define CPTC_SCALE_MAX    5'h1c
`define CPTC_DELTA_MAX    32'h0000ffff
`define CPTC_OP_IDLE      2'h0
`define CPTC_OP_FREE      2'h1
`define CPTC_OP_COUNTED   2'h2
`endif

// file: logic/cptc_buf2.v
// two-entry valid/ready buffer for captured samples
`timescale 1ns/1ps
`default_nettype none
module cptc_buf2 (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        flush_i,
    input  wire        in_valid_i,
    output wire        in_ready_o,
    input  wire [29:0] in_data_i,
    output wire        out_valid_o,
    input  wire        out_ready_i,
    output wire [29:0] out_data_o
);
    reg  [29:0] mem_q [0:1];
    reg         wr_q;
    reg         rd_q;
    reg  [1:0]  cnt_q;
    wire        push;
    wire        pop;

    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // -----------------------------------------
    // storage and pointers
    // -----------------------------------------
    always @(posedge clk_i) begin
        if (!reset_n_i || flush_i) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data_i;
                wr_q        <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// file: logic/cptc_capture.v
// top of the timestamp capture block: counter, edge qualify, buffer, delta
`timescale 1ns/1ps
`default_nettype none
`include "cptc_defs.vh"
module cptc_capture (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        signal_i,
    input  wire        gate_i,
    input  wire        cfg_gate_en_i,
    input  wire        cfg_gate_pol_i,
    input  wire        cfg_dual_edge_i,
    input  wire        cfg_falling_i,
    input  wire        cfg_gate_level_i,
    input  wire [4:0]  cfg_scale_i,
    input  wire        start_i,
    input  wire        stop_i,
    input  wire        flush_i,
    input  wire [1:0]  operation_select_i,
    input  wire        collect_i,
    input  wire [15:0] sample_count_i,
    output reg  [7:0]  byte_o,
    output reg         byte_valid_o,
    input  wire        byte_ready_i,
    output reg         byte_last_o,
    output reg  [15:0] delta_o,
    output reg         delta_ovf_o,
    output reg         running_o,
    output reg         collecting_o,
    output reg         overrun_o,
    output reg         stop_overrun_o,
    output reg         scale_err_o,
    output reg         done_o
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ARM  = 2'h1;
    localparam [1:0] ST_RUN  = 2'h2;
    localparam [4:0] TICK_W  = `CPTC_TICK_CYC;

    reg  [1:0]  st_q;
    reg  [1:0]  op_q;
    reg  [4:0]  tick_q;
    reg  [27:0] cnt_q;
    reg  [27:0] prev_q;
    reg  [15:0] remain_q;
    reg         sig_q;
    reg         gate_q;
    reg         tick_en_q;
    reg  [1:0]  byte_idx_q;
    reg         have_q;
    reg  [29:0] cur_q;
    reg  [4:0]  scale_q;
    wire        gate_act;
    wire        edge_hit;
    wire        cap;
    wire        buf_ready;
    wire        buf_valid;
    wire [29:0] buf_data;
    wire        pop;
    wire        flush_all;
    wire        ovf_evt;
    wire [27:0] diff;
    wire [27:0] scaled;

    // decide whether a signal transition counts as an edge
    function edge_sel;
        input rise;
        input fall;
        input dual;
        input neg;
        begin
            edge_sel = dual ? (rise | fall) : (neg ? fall : rise);
        end
    endfunction

    // gate decode, shared by the level gate and the one-time trigger arm
    function gate_on;
        input level;
        input pol;
        begin
            gate_on = pol ? level : ~level;
        end
    endfunction

    // -----------------------------------------
    // timestamp counter
    // -----------------------------------------
    // the count only halts on stop and is cleared only by reset; the first delta
    // after a stop is taken against zero, so the host must discard it
    // 0.1 us tick
    always @(posedge clk_i) begin
        if (!reset_n_i || !running_o) begin
            tick_q    <= 5'h0;
            tick_en_q <= 1'b0;
        end else if (tick_q == TICK_W - 5'h1) begin
            tick_q    <= 5'h0;
            tick_en_q <= 1'b1;
        end else begin
            tick_q    <= tick_q + 5'h1;
            tick_en_q <= 1'b0;
        end
    end

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            cnt_q <= 28'h0;
        end else if (tick_en_q && running_o) begin
            cnt_q <= cnt_q + 28'h1;
        end
    end

    // -----------------------------------------
    // edge and gate qualification
    // -----------------------------------------
    // inputs are taken as synchronous; one register gives edge history
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            sig_q  <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            sig_q  <= signal_i;
            gate_q <= gate_i;
        end
    end

    assign gate_act = gate_on(gate_i, cfg_gate_pol_i);
    assign edge_hit = edge_sel(signal_i & ~sig_q, ~signal_i & sig_q,
                               cfg_dual_edge_i, cfg_falling_i);
    // level gate checks each capture; trigger only arms once
    // a capture in a stop or flush cycle is dropped on purpose: the buffer is
    // emptied at that edge anyway, and a late overrun must not outlive the clear
    assign cap = (st_q == ST_RUN) && running_o && edge_hit && !stop_i && !flush_i &&
                 (!cfg_gate_en_i || !cfg_gate_level_i || gate_act);
    assign ovf_evt   = cap && !buf_ready;
    // stop and flush empty the buffer
    assign flush_all = stop_i | flush_i |
                       ((op_q == `CPTC_OP_COUNTED) && (st_q == ST_RUN) &&
                        (ovf_evt || remain_q == 16'h0));

    // -----------------------------------------
    // collection state machine
    // -----------------------------------------
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_q         <= ST_IDLE;
            op_q         <= `CPTC_OP_IDLE;
            running_o    <= 1'b0;
            collecting_o <= 1'b0;
            remain_q     <= 16'h0;
            done_o       <= 1'b0;
        end else if (stop_i) begin
            // stop halts counter and ends any collection
            st_q         <= ST_IDLE;
            op_q         <= `CPTC_OP_IDLE;
            running_o    <= 1'b0;
            collecting_o <= 1'b0;
        end else begin
            if (start_i) begin
                running_o <= 1'b1;
            end
            case (st_q)
                ST_IDLE: begin
                    if (collect_i && operation_select_i != `CPTC_OP_IDLE) begin
                        running_o    <= 1'b1;
                        collecting_o <= 1'b1;
                        op_q         <= operation_select_i;
                        remain_q     <= sample_count_i;
                        done_o       <= 1'b0;
                        st_q         <= (cfg_gate_en_i && !cfg_gate_level_i) ?
                                        ST_ARM : ST_RUN;
                    end
                end
                ST_ARM: begin
                    // trigger mode waits for the gate once
                    if (gate_on(gate_i, cfg_gate_pol_i)) begin
                        st_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // counted collection ends on count done or overrun
                    if (op_q == `CPTC_OP_COUNTED) begin
                        if (ovf_evt || remain_q == 16'h0) begin
                            st_q         <= ST_IDLE;
                            op_q         <= `CPTC_OP_IDLE;
                            collecting_o <= 1'b0;
                            done_o       <= ~ovf_evt;
                        end else if (cap) begin
                            remain_q <= remain_q - 16'h1;
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------
    // overrun tracking
    // -----------------------------------------
    // set on capture into full buffer; stop or flush wins, as no capture is taken in that cycle
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            overrun_o      <= 1'b0;
            stop_overrun_o <= 1'b0;
        end else begin
            if (ovf_evt) begin
                overrun_o <= 1'b1;
            end else if (stop_i || flush_i) begin
                overrun_o <= 1'b0;
            end
            if (stop_i) begin
                stop_overrun_o <= overrun_o | ovf_evt;
            end else if (start_i || collect_i) begin
                stop_overrun_o <= 1'b0;
            end
        end
    end

    // sample word: count plus inverted gate and signal levels
    // the levels are the registered ones, so they show the pins one cycle
    // before the qualifying edge; two entries ride out a short host stall
    cptc_buf2 u_buf (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .flush_i     (flush_all),
        .in_valid_i  (cap),
        .in_ready_o  (buf_ready),
        .in_data_i   ({cnt_q, ~gate_q, ~sig_q}),
        .out_valid_o (buf_valid),
        .out_ready_i (pop),
        .out_data_o  (buf_data)
    );

    // -----------------------------------------
    // byte serializer and delta
    // -----------------------------------------
    // one sample is unpacked at a time; the next pops once the fourth byte goes
    assign pop = buf_valid && !have_q;
    assign diff   = cur_q[29:2] - prev_q;
    assign scaled = diff >> scale_q;

    always @(posedge clk_i) begin
        if (!reset_n_i || stop_i || flush_i) begin
            have_q       <= 1'b0;
            byte_idx_q   <= 2'h0;
            byte_valid_o <= 1'b0;
            byte_last_o  <= 1'b0;
            byte_o       <= 8'h0;
            cur_q        <= 30'h0;
        end else if (pop) begin
            have_q       <= 1'b1;
            cur_q        <= buf_data;
            byte_idx_q   <= 2'h0;
            byte_valid_o <= 1'b1;
            byte_last_o  <= 1'b0;
            // low nibble of count, inverted gate, inverted signal, zeros
            byte_o       <= {buf_data[5:2], buf_data[1], buf_data[0], 2'h0};
        end else if (byte_valid_o && byte_ready_i) begin
            case (byte_idx_q)
                2'h0: begin
                    byte_o     <= cur_q[13:6];
                    byte_idx_q <= 2'h1;
                end
                2'h1: begin
                    byte_o     <= cur_q[21:14];
                    byte_idx_q <= 2'h2;
                end
                2'h2: begin
                    byte_o      <= cur_q[29:22];
                    byte_idx_q  <= 2'h3;
                    byte_last_o <= 1'b1;
                end
                default: begin
                    have_q       <= 1'b0;
                    byte_valid_o <= 1'b0;
                    byte_last_o  <= 1'b0;
                end
            endcase
        end
    end

    // delta is published once a sample's last byte is taken
    // waiting for the last byte costs latency but keeps delta paired with
    // the word the host has just assembled
    always @(posedge clk_i) begin
        if (!reset_n_i || stop_i) begin
            prev_q      <= 28'h0;
            delta_o     <= 16'h0;
            delta_ovf_o <= 1'b0;
            scale_q     <= 5'h0;
            scale_err_o <= 1'b0;
        end else begin
            // scale above 28 refused, old one kept
            if (cfg_scale_i > `CPTC_SCALE_MAX) begin
                scale_err_o <= 1'b1;
            end else begin
                scale_q     <= cfg_scale_i;
                scale_err_o <= 1'b0;
            end
            if (byte_last_o && byte_valid_o && byte_ready_i) begin
                prev_q <= cur_q[29:2];
                // oversized delta reads zero with overflow set
                if (scaled > 28'h000ffff) begin
                    delta_o     <= 16'h0;
                    delta_ovf_o <= 1'b1;
                end else begin
                    delta_o     <= scaled[15:0];
                    delta_ovf_o <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/cptc_host_sink.sv
// host-side model that drains capture bytes
`timescale 1ns/1ps
`default_nettype none
module cptc_host_sink (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        stall_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic        valid_i,
    input  wire logic        last_i,
    output wire logic        ready_o,
    output var  logic [31:0] word_o,
    output var  logic [15:0] count_o
);
    logic        slow_q;
    logic [31:0] acc_q;
    // drain rate: every other cycle, so the host is slow but keeps up
    assign ready_o = !stall_i && slow_q;
    // assemble four bytes, least significant first
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            slow_q  <= 1'b0;
            acc_q   <= 32'h0;
            word_o  <= 32'h0;
            count_o <= 16'h0;
        end else begin
            slow_q <= ~slow_q;
            if (valid_i && ready_o) begin
                acc_q <= {byte_i, acc_q[31:8]};
                if (last_i) begin
                    word_o  <= {byte_i, acc_q[31:8]};
                    count_o <= count_o + 16'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/cptc_capture_assertions.sv
// concurrent checks on the capture block ports
`timescale 1ns/1ps
`default_nettype none
module cptc_capture_assertions (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        start_i,
    input wire logic        stop_i,
    input wire logic        flush_i,
    input wire logic        collect_i,
    input wire logic [1:0]  operation_select_i,
    input wire logic [7:0]  byte_o,
    input wire logic        byte_valid_o,
    input wire logic        byte_ready_i,
    input wire logic        byte_last_o,
    input wire logic [15:0] delta_o,
    input wire logic        delta_ovf_o,
    input wire logic        running_o,
    input wire logic        collecting_o,
    input wire logic        overrun_o,
    input wire logic        stop_overrun_o,
    input wire logic        done_o
);
    logic [1:0] nb_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // byte position in a sample; stop and flush realign it
    always @(posedge clk_i) begin
        if (!reset_n_i || stop_i || flush_i) begin
            nb_q <= 2'h0;
        end else if (byte_valid_o && byte_ready_i) begin
            nb_q <= nb_q + 2'h1;
        end
    end
    a_last_byte: assert property (byte_valid_o |-> byte_last_o == (nb_q == 2'h3))
        else $error("last flag off the fourth byte");
    a_byte_hold: assert property (
        byte_valid_o && !byte_ready_i && !stop_i && !flush_i && collecting_o
        |=> byte_valid_o && $stable(byte_o) || !collecting_o)
        else $error("byte changed while stalled");
    a_start_only: assert property (
        start_i && !stop_i && !collect_i && !collecting_o |=> running_o && !collecting_o)
        else $error("start misbehaved");
    a_collect_runs: assert property (
        collect_i && operation_select_i == 2'h1 && !stop_i && !collecting_o
        |=> running_o && collecting_o)
        else $error("collect left counter stopped");
    a_stop_halts: assert property (
        stop_i |=> !running_o && !collecting_o ##1 !byte_valid_o)
        else $error("stop did not halt and flush");
    a_stop_overrun: assert property (stop_i && overrun_o |=> stop_overrun_o)
        else $error("overrun at stop not reported");
    a_overrun_clear: assert property (stop_i || flush_i |=> !overrun_o)
        else $error("overrun not cleared");
    a_delta_zero: assert property (delta_ovf_o |-> delta_o == 16'h0)
        else $error("overflowed delta not zero");
    a_done_idle: assert property ($rose(done_o) |-> !collecting_o)
        else $error("done while collecting");
endmodule
bind cptc_capture cptc_capture_assertions u_chk (.clk_i, .reset_n_i, .start_i, .stop_i,
    .flush_i, .collect_i, .operation_select_i, .byte_o, .byte_valid_o, .byte_ready_i,
    .byte_last_o, .delta_o, .delta_ovf_o, .running_o, .collecting_o, .overrun_o,
    .stop_overrun_o, .done_o);
`default_nettype wire

// file: tb/cptc_capture_test.sv
// self-checking bench for the timestamp capture block
`timescale 1ns/1ps
`default_nettype none
module cptc_capture_test;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        signal_i = 1'b0;
    logic        gate_i = 1'b0;
    logic [4:0]  g = 5'h00;
    logic [4:0]  cfg_scale_i = 5'h00;
    logic        start_i = 1'b0;
    logic        stop_i = 1'b0;
    logic        flush_i = 1'b0;
    logic        collect_i = 1'b0;
    logic [1:0]  operation_select_i = 2'h0;
    logic [15:0] sample_count_i = 16'h0;
    logic [7:0]  byte_o;
    logic        byte_valid_o, byte_ready_i, byte_last_o, delta_ovf_o, running_o;
    logic        collecting_o, overrun_o, stop_overrun_o, scale_err_o, done_o;
    logic        gen_q = 1'b0;
    logic        stall = 1'b0;
    logic [15:0] delta_o, cnt, base;
    logic [31:0] word, w0, w1;
    int          ph = 0;
    int          cyc_n = 0;
    int          bad_count = 0;
    int          n_tests = 0;
    int          sc[3] = '{0, 1, 3};
    cptc_capture uut (.clk_i, .reset_n_i, .signal_i, .gate_i, .cfg_gate_en_i(g[4]),
        .cfg_gate_pol_i(g[3]), .cfg_dual_edge_i(g[2]), .cfg_falling_i(g[1]),
        .cfg_gate_level_i(g[0]), .cfg_scale_i, .start_i, .stop_i, .flush_i,
        .operation_select_i, .collect_i, .sample_count_i, .byte_o, .byte_valid_o,
        .byte_ready_i, .byte_last_o, .delta_o, .delta_ovf_o, .running_o, .collecting_o,
        .overrun_o, .stop_overrun_o, .scale_err_o, .done_o);
    cptc_host_sink host (.clk_i, .reset_n_i, .stall_i(stall), .byte_i(byte_o),
        .valid_i(byte_valid_o), .last_i(byte_last_o), .ready_o(byte_ready_i),
        .word_o(word), .count_o(cnt));
    always #2 clk_i = ~clk_i;
    // signal toggles every 125 cycles (5 ticks); cycle ceiling cuts a hang
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        ph <= (ph == 124) ? 0 : ph + 1;
        if (gen_q && ph == 124) begin
            signal_i <= ~signal_i;
        end
        if (cyc_n == 40000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: got %0h want %0h", $time, what, got, exp);
        end
    endtask
    // one-cycle pulse of {start, stop, flush, collect}
    task automatic cmd(input logic [3:0] c);
        {start_i, stop_i, flush_i, collect_i} <= c;
        cyc(1);
        {start_i, stop_i, flush_i, collect_i} <= 4'h0;
        cyc(2);
    endtask
    task automatic cfg(input logic [4:0] gv, input logic [4:0] s);
        g <= gv;
        cfg_scale_i <= s;
        cyc(2);
    endtask
    task automatic take(output logic [31:0] w);
        base = cnt;
        for (int i = 0; i < 2000 && cnt == base; i++) cyc(1);
        chk(cnt - base, 32'h1, "one sample");
        cyc(2);
        w = word;
    endtask
    task automatic quiet(input int n);
        base = cnt;
        cyc(n);
        chk(cnt, base, "no sample");
    endtask
    function automatic logic [27:0] ts(input logic [31:0] w);
        return {w[31:8], w[7:4]};
    endfunction
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        cyc(3);
        reset_n_i <= 1'b1;
        gen_q <= 1'b1;
        // address, interrupt level and channel live outside this block
        cfg(5'h00, 5'h00);
        cmd(4'h8);
        quiet(600);
        chk(running_o, 1'b1, "start runs counter");
        cmd(4'h4);
        operation_select_i <= 2'h1;
        cmd(4'h1);
        chk({running_o, collecting_o}, 2'h3, "collect starts counter");
        foreach (sc[i]) begin
            cfg(5'h00, 5'(sc[i]));
            take(w0);
            take(w1);
            chk(ts(w1) - ts(w0), 28'd10, "rise interval");
            chk(delta_o, 16'd10 >> sc[i], "scaled delta");
            chk(delta_ovf_o, 1'b0, "no delta overflow");
            chk(w1[1:0], 2'h0, "low bits");
        end
        cfg(5'h02, 5'h00);
        take(w0);
        chk(ts(w0) - ts(w1), 28'd5, "falling edge");
        cfg(5'h04, 5'h00);
        take(w0);
        take(w1);
        chk(ts(w1) - ts(w0), 28'd5, "both edges");
        chk(delta_o, 16'd5, "dual delta");
        cfg(5'h19, 5'h00);
        quiet(600);
        gate_i <= 1'b1;
        take(w0);
        chk(w0[3], 1'b0, "inverted gate bit");
        cfg(5'h11, 5'h00);
        quiet(600);
        gate_i <= 1'b0;
        take(w0);
        chk(w0[3], 1'b1, "inverted gate bit");
        cmd(4'h4);
        cfg(5'h18, 5'h00);
        cmd(4'h1);
        quiet(600);
        gate_i <= 1'b1;
        cyc(10);
        gate_i <= 1'b0;
        take(w0);
        take(w1);
        cfg(5'h00, 5'h00);
        stall <= 1'b1;
        cyc(1500);
        chk(overrun_o, 1'b1, "overrun on full buffer");
        cmd(4'h2);
        chk(overrun_o, 1'b0, "flush clears overrun");
        cyc(1500);
        cmd(4'h4);
        chk({stop_overrun_o, overrun_o, running_o, byte_valid_o}, 4'h8, "stop");
        stall <= 1'b0;
        quiet(100);
        operation_select_i <= 2'h2;
        sample_count_i <= 16'h2;
        w0 = {16'h0, cnt};
        cmd(4'h1);
        for (int i = 0; i < 3000 && done_o !== 1'b1; i++) cyc(1);
        chk({done_o, collecting_o}, 2'h2, "counted end");
        cyc(20);
        chk(cnt - w0[15:0], 32'h2, "counted samples");
        cfg(5'h00, 5'd29);
        chk(scale_err_o, 1'b1, "scale refused");
        summarize();
    end
endmodule
`default_nettype wire
